/* logic/host_port_pkg.sv */
// constants for the host serial register port
package host_port_pkg;
   localparam logic [7:0] ADDR_UNLOCK_A    = 8'h6B;
   localparam logic [7:0] ADDR_UNLOCK_B    = 8'h6D;
   localparam logic [7:0] ADDR_UNLOCK_C    = 8'h6F;
   localparam logic [7:0] ADDR_TEST_FIRST  = 8'h70;
   localparam logic [7:0] ADDR_TEST_LAST   = 8'h77;
   localparam int         UNLOCK_A_BIT     = 0;
   localparam int         UNLOCK_B_BIT     = 4;
   localparam int         UNLOCK_C_BIT     = 7;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam int         READ_FLAG_BIT    = 7;
   localparam int         REG_ADDR_W       = 7;
   localparam logic [4:0] ADDR_LAST_BIT    = 5'h07;
   localparam logic [4:0] FRAME_LAST_BIT   = 5'h0F;

   typedef enum logic [2:0]
   {
      ST_ADDR  = 3'b000,
      ST_CMD   = 3'b001,
      ST_FETCH = 3'b010,
      ST_LOAD  = 3'b011,
      ST_TX    = 3'b100,
      ST_DONE  = 3'b101
   } port_state_e;
endpackage : host_port_pkg

/* logic/reg_mem.sv */
// register storage, one write port, registered read
`timescale 1ns/1ps
`default_nettype none
module reg_mem
(
   // clock
   input  wire logic                                   clk,
   // write port
   input  wire logic                                   we,
   input  wire logic [host_port_pkg::REG_ADDR_W-1:0]   wr_addr,
   input  wire logic [7:0]                             wr_data,
   // read port
   input  wire logic [host_port_pkg::REG_ADDR_W-1:0]   rd_addr,
   output var  logic [7:0]                             rd_data
);
   import host_port_pkg::*;

   logic [7:0] mem [0:(1<<REG_ADDR_W)-1];

   initial
   begin
      for (int i = 0; i < (1<<REG_ADDR_W); i++)
      begin
         mem[i] = REG_RESET;
      end
   end

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule : reg_mem
`default_nettype wire

/* logic/host_serial_port.sv */
// host serial register port with factory test write lock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - three unlock bits: 0x6B bit0, 0x6D bit4, 0x6F bit7; read/write, reset zero
// - writes to 0x70..0x77 take effect only while all three unlock bits are set
// - 0x70 is an eight bit read/write test byte, reset zero
// - frame lands in a sixteen bit shift register, address then command, then decoded
// - an eight bit transmit register carries read data out on the data output
// - four link signals: clock, data in, data out, chip enable; host drives all but out
// - data in shifts on each rising serial clock edge of the address byte and, in a write, the command byte
// - bits accepted only while chip enable high; host holds it for the frame
// - read: address byte in, at most eight data bits back, MSB first
// - display RAM is never returned; reads reach registers only
module host_serial_port
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // serial link pins
   input  wire logic        serial_clk,
   input  wire logic        serial_data_in,
   input  wire logic        chip_enable,
   output var  logic        serial_data_out,
   // lock status
   output var  logic        test_unlocked
);
   import host_port_pkg::*;

   function automatic logic in_test_range(input logic [7:0] a);
      in_test_range = (a >= ADDR_TEST_FIRST) && (a <= ADDR_TEST_LAST);
   endfunction : in_test_range

   // pin synchronisers
   logic [1:0]  sck_sync;
   logic [1:0]  sdi_sync;
   logic [1:0]  ce_sync;
   logic        sck_prev;
   logic        sck_s;
   logic        sdi_s;
   logic        ce_s;
   logic        sck_rise;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_sync <= 2'h0;
         sdi_sync <= 2'h0;
         ce_sync  <= 2'h0;
         sck_prev <= 1'b0;
      end
      else
      begin
         sck_sync <= {sck_sync[0], serial_clk};
         sdi_sync <= {sdi_sync[0], serial_data_in};
         ce_sync  <= {ce_sync[0], chip_enable};
         sck_prev <= sck_sync[1];
      end
   end

   assign sck_s    = sck_sync[1];
   assign sdi_s    = sdi_sync[1];
   assign ce_s     = ce_sync[1];
   assign sck_rise = sck_s & ~sck_prev;

   // frame engine
   port_state_e state;
   port_state_e next_state;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [4:0]  cnt;
   logic [4:0]  next_cnt;
   logic [7:0]  tx;
   logic [7:0]  next_tx;
   logic [7:0]  unlock_a;
   logic [7:0]  unlock_b;
   logic [7:0]  unlock_c;
   logic [7:0]  next_unlock_a;
   logic [7:0]  next_unlock_b;
   logic [7:0]  next_unlock_c;
   logic [7:0]  test_first;
   logic [7:0]  next_test_first;
   logic [7:0]  mem_rd;
   logic [7:0]  rd_mux;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        wr_go;
   logic        wr_ok;
   logic        mem_we;
   logic        unlocked;

   assign unlocked = unlock_a[UNLOCK_A_BIT] & unlock_b[UNLOCK_B_BIT]
                     & unlock_c[UNLOCK_C_BIT];
   assign test_unlocked = unlocked;

   // commit decode at sixteenth edge
   assign wr_addr = shreg[14:7];
   assign wr_data = {shreg[6:0], sdi_s};
   assign wr_go   = ce_s && sck_rise && (state == ST_CMD) && (cnt == FRAME_LAST_BIT);
   assign wr_ok   = !in_test_range(wr_addr) || unlocked;
   assign mem_we  = wr_go && wr_ok && (wr_addr != ADDR_UNLOCK_A)
                    && (wr_addr != ADDR_UNLOCK_B) && (wr_addr != ADDR_UNLOCK_C)
                    && (wr_addr != ADDR_TEST_FIRST);

   // registers only; no display memory path
   always_comb
   begin
      case (shreg[7:0] & 8'h7F)
         ADDR_UNLOCK_A: rd_mux = unlock_a;
         ADDR_UNLOCK_B: rd_mux = unlock_b;
         ADDR_UNLOCK_C: rd_mux = unlock_c;
         ADDR_TEST_FIRST: rd_mux = test_first;
         default:       rd_mux = mem_rd;
      endcase
   end

   reg_mem u_mem
   (
      .clk     (clk),
      .we      (mem_we),
      .wr_addr (wr_addr[REG_ADDR_W-1:0]),
      .wr_data (wr_data),
      .rd_addr (shreg[REG_ADDR_W-1:0]),
      .rd_data (mem_rd)
   );

   always_comb
   begin
      next_state    = state;
      next_shreg    = shreg;
      next_cnt      = cnt;
      next_tx       = tx;
      next_unlock_a = unlock_a;
      next_unlock_b = unlock_b;
      next_unlock_c = unlock_c;
      next_test_first = test_first;
      if (!ce_s)
      begin
         next_state = ST_ADDR;
         next_cnt   = 5'h00;
         next_tx    = 8'h00;
      end
      else
      begin
         case (state)
            ST_ADDR:
            begin
               if (sck_rise)
               begin
                  next_shreg = {shreg[14:0], sdi_s};
                  next_cnt   = cnt + 5'h01;
                  if (cnt == ADDR_LAST_BIT)
                  begin
                     next_state = shreg[READ_FLAG_BIT-1] ? ST_FETCH : ST_CMD;
                  end
               end
            end
            ST_CMD:
            begin
               if (sck_rise)
               begin
                  next_shreg = {shreg[14:0], sdi_s};
                  next_cnt   = cnt + 5'h01;
                  if (cnt == FRAME_LAST_BIT)
                  begin
                     next_state = ST_DONE;
                  end
               end
            end
            ST_FETCH: next_state = ST_LOAD;
            ST_LOAD:
            begin
               next_tx    = rd_mux;
               next_state = ST_TX;
            end
            ST_TX:
            begin
               if (sck_rise)
               begin
                  next_tx  = {tx[6:0], 1'b0};
                  next_cnt = cnt + 5'h01;
                  if (cnt == FRAME_LAST_BIT)
                  begin
                     next_state = ST_DONE;
                  end
               end
            end
            ST_DONE: next_state = ST_DONE;
            default: next_state = ST_ADDR;
         endcase
      end
      if (wr_go)
      begin
         if (wr_addr == ADDR_UNLOCK_A) next_unlock_a = wr_data;
         if (wr_addr == ADDR_UNLOCK_B) next_unlock_b = wr_data;
         if (wr_addr == ADDR_UNLOCK_C) next_unlock_c = wr_data;
         if ((wr_addr == ADDR_TEST_FIRST) && wr_ok) next_test_first = wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state    <= ST_ADDR;
         shreg    <= 16'h0000;
         cnt      <= 5'h00;
         tx       <= 8'h00;
         unlock_a <= REG_RESET;
         unlock_b <= REG_RESET;
         unlock_c <= REG_RESET;
         test_first <= REG_RESET;
      end
      else
      begin
         state    <= next_state;
         shreg    <= next_shreg;
         cnt      <= next_cnt;
         tx       <= next_tx;
         unlock_a <= next_unlock_a;
         unlock_b <= next_unlock_b;
         unlock_c <= next_unlock_c;
         test_first <= next_test_first;
      end
   end

   assign serial_data_out = tx[7];

   unlock_reset_a: assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> (unlocked == 1'b0) && (unlock_a == REG_RESET)
      && (test_first == REG_RESET))
      else $error("unlock bits not clear after reset");

   locked_range_a: assert property (@(posedge clk) disable iff (rst)
      (mem_we && in_test_range(wr_addr)) |-> unlocked)
      else $error("test range written while locked");

   first_test_lock_a: assert property (@(posedge clk) disable iff (rst)
      (wr_go && (wr_addr == ADDR_TEST_FIRST) && !unlocked)
      |=> (test_first == $past(test_first)))
      else $error("first test byte written while locked");

   commit_edge_a: assert property (@(posedge clk) disable iff (rst)
      mem_we |-> (state == ST_CMD) && (cnt == FRAME_LAST_BIT) && sck_rise && ce_s)
      else $error("write committed outside sixteenth edge");

   enable_drop_a: assert property (@(posedge clk) disable iff (rst)
      !ce_s |=> (state == ST_ADDR) && (cnt == 5'h00) && (tx == 8'h00))
      else $error("frame not dropped on enable low");

   shift_in_a: assert property (@(posedge clk) disable iff (rst)
      (ce_s && sck_rise && state == ST_ADDR) |=> (shreg[0] == $past(sdi_s)))
      else $error("data in not shifted on rising edge");

   addr_decode_a: assert property (@(posedge clk) disable iff (rst)
      (ce_s && sck_rise && state == ST_ADDR && cnt == ADDR_LAST_BIT)
      |=> (state == ($past(shreg[6]) ? ST_FETCH : ST_CMD)))
      else $error("address byte wrongly decoded");

   tx_load_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_FETCH && ce_s) ##1 (state == ST_LOAD && ce_s)
      |=> (state == ST_TX) && (tx == $past(rd_mux)))
      else $error("transmit register not loaded after address");

   tx_shift_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_TX && ce_s && sck_rise)
      |=> (serial_data_out == $past(tx[6])))
      else $error("read bit order wrong");

   quiet_out_a: assert property (@(posedge clk) disable iff (rst)
      (state == ST_CMD) |-> !serial_data_out)
      else $error("data out driven during write");
endmodule : host_serial_port
`default_nettype wire

/* sim/host_master.sv */
// host microcomputer model driving the serial register link
`timescale 1ns/1ps
`default_nettype none
module host_master
(
   // pacing clock
   input  wire logic clk,
   // serial link pins
   output var  logic serial_clk,
   output var  logic serial_data_in,
   output var  logic chip_enable,
   input  wire logic serial_data_out
);
   initial
   begin
      serial_clk     = 1'b0;
      serial_data_in = 1'b0;
      chip_enable    = 1'b0;
   end

   // 8 system clocks a serial period: 200 ns, under both speed ceilings
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
      rdata = 8'h00;
      @(negedge clk);
      chip_enable = 1'b1;
      for (int i = 0; i < nbits; i++)
      begin
         serial_data_in = word[15-i];
         repeat (4) @(negedge clk);
         if (i >= 8)
            rdata = {rdata[6:0], serial_data_out};
         serial_clk = 1'b1;
         repeat (4) @(negedge clk);
         serial_clk = 1'b0;
      end
      // released data line must not keep its last value
      serial_data_in = ~serial_data_in;
      chip_enable    = 1'b0;
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : host_master
`default_nettype wire

/* sim/tb_host_serial_port.sv */
// self-checking bench for the host serial register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_host_serial_port;
   import host_port_pkg::*;
   logic       clk;
   logic       rst;
   wire logic  serial_clk;
   wire logic  serial_data_in;
   wire logic  chip_enable;
   wire logic  serial_data_out;
   wire logic  test_unlocked;
   logic [7:0] q;
   int         err_count   = 0;
   int         checks_done = 0;
   int         cycles      = 0;

   host_serial_port i_dut
   (
      .clk             (clk),
      .rst             (rst),
      .serial_clk      (serial_clk),
      .serial_data_in  (serial_data_in),
      .chip_enable     (chip_enable),
      .serial_data_out (serial_data_out),
      .test_unlocked   (test_unlocked)
   );

   host_master i_host
   (
      .clk             (clk),
      .serial_clk      (serial_clk),
      .serial_data_in  (serial_data_in),
      .chip_enable     (chip_enable),
      .serial_data_out (serial_data_out)
   );

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic results;
      $display("errors=%0d checks=%0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      i_host.xfer({1'b0, addr[6:0], data}, 16, q);
   endtask : wr

   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      i_host.xfer({1'b1, addr[6:0], 8'h00}, 16, q);
      `CHK(q, exp)
      `CHK(serial_data_out, 1'b0)
   endtask : rd

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         results();
      end
   end

   initial
   begin
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(serial_data_out, 1'b0)
      `CHK(test_unlocked, 1'b0)
      rd(ADDR_UNLOCK_A, REG_RESET);
      rd(ADDR_UNLOCK_B, REG_RESET);
      rd(ADDR_UNLOCK_C, REG_RESET);
      rd(ADDR_TEST_FIRST, REG_RESET);
      // locked: test range writes dropped, neighbours outside it accepted
      wr(ADDR_TEST_FIRST, 8'hA5);
      rd(ADDR_TEST_FIRST, REG_RESET);
      wr(8'h78, 8'h96);
      rd(8'h78, 8'h96);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h5A);
      // unlock one bit at a time
      wr(ADDR_UNLOCK_A, 8'h01);
      wr(ADDR_UNLOCK_B, 8'h10);
      `CHK(test_unlocked, 1'b0)
      wr(ADDR_UNLOCK_C, 8'h80);
      `CHK(test_unlocked, 1'b1)
      rd(ADDR_UNLOCK_A, 8'h01);
      rd(ADDR_UNLOCK_B, 8'h10);
      rd(ADDR_UNLOCK_C, 8'h80);
      wr(ADDR_TEST_FIRST, 8'hA5);
      wr(ADDR_TEST_LAST, 8'h3C);
      rd(ADDR_TEST_FIRST, 8'hA5);
      rd(ADDR_TEST_LAST, 8'h3C);
      // frame cut short after twelve edges
      i_host.xfer({1'b0, ADDR_TEST_FIRST[6:0], 8'hFF}, 12, q);
      rd(ADDR_TEST_FIRST, 8'hA5);
      // clearing only the middle lock bit relocks
      wr(ADDR_UNLOCK_B, 8'hEF);
      `CHK(test_unlocked, 1'b0)
      wr(ADDR_TEST_LAST, 8'h55);
      rd(ADDR_TEST_LAST, 8'h3C);
      rd(ADDR_UNLOCK_B, 8'hEF);
      // mid-run reset drops the lock and the first test byte
      wr(ADDR_UNLOCK_B, 8'h10);
      `CHK(test_unlocked, 1'b1)
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(test_unlocked, 1'b0)
      rd(ADDR_UNLOCK_C, REG_RESET);
      rd(ADDR_TEST_FIRST, REG_RESET);
      results();
   end
endmodule : tb_host_serial_port
`default_nettype wire
